// file: hw/ecs_pkg.sv
// ecs_pkg: register map, field positions, reset values and size codes of the expansion chip-select unit.
// assumes: APB slave with 32-bit data; each 8-bit register sits in the low byte of one aligned word.
package ecs_pkg;
	// printed offsets are not all multiples of four: they are register indices, byte address = 4 * index
	localparam logic [15:0] ECS_IDX_STRETCH = 16'h105C;
	localparam logic [15:0] ECS_IDX_CONTROL = 16'h105D;
	localparam logic [15:0] ECS_IDX_GP_BASE = 16'h105E;
	localparam logic [15:0] ECS_IDX_GP_SIZE = 16'h105F;
	localparam logic [15:0] ECS_IDX_REGBASE = 16'h1060;
	localparam logic [15:0] ECS_IDX_STATUS  = 16'h1061;
	localparam int          ECS_AW          = 18;
	localparam logic [17:0] ECS_ADR_STRETCH = {ECS_IDX_STRETCH, 2'b00};
	localparam logic [17:0] ECS_ADR_CONTROL = {ECS_IDX_CONTROL, 2'b00};
	localparam logic [17:0] ECS_ADR_GP_BASE = {ECS_IDX_GP_BASE, 2'b00};
	localparam logic [17:0] ECS_ADR_GP_SIZE = {ECS_IDX_GP_SIZE, 2'b00};
	localparam logic [17:0] ECS_ADR_REGBASE = {ECS_IDX_REGBASE, 2'b00};
	localparam logic [17:0] ECS_ADR_STATUS  = {ECS_IDX_STATUS, 2'b00};

	// reset values
	localparam logic [7:0] ECS_RST_STRETCH = 8'h00;
	localparam logic [7:0] ECS_RST_CONTROL = 8'h00;
	localparam logic [7:0] ECS_RST_GP_BASE = 8'h00;
	localparam logic [7:0] ECS_RST_GP_SIZE = 8'h07;
	localparam logic [3:0] ECS_RST_REGBASE = 4'h1;
	localparam logic [1:0] ECS_STR_ONE     = 2'h1;
	localparam logic [7:0] ECS_GP_BASE_WM  = 8'hFC;   // low two bits read as zero
	localparam logic [7:0] ECS_GP_SIZE_WM  = 8'hDF;   // bit 5 reads as zero

	// stretch register fields
	localparam int ECS_STR_IO1 = 6;
	localparam int ECS_STR_IO2 = 4;
	localparam int ECS_STR_GP  = 2;
	localparam int ECS_STR_PRG = 0;
	// control register fields
	localparam int ECS_CTL_IO_SEL1_ENABLE = 7;
	localparam int ECS_CTL_IO_SEL1_POLARITY = 6;
	localparam int ECS_CTL_IO_SEL2_ENABLE = 5;
	localparam int ECS_CTL_IO_SEL2_POLARITY = 4;
	localparam int ECS_CTL_GPRI  = 3;
	localparam int ECS_CTL_PEN   = 2;
	localparam int ECS_CTL_PSIZ  = 0;
	// gp size / timing register fields
	localparam int ECS_GSZ_IO_SEL1_TIMING = 7;
	localparam int ECS_GSZ_IO_SEL2_TIMING = 6;
	localparam int ECS_GSZ_GPOL  = 4;
	localparam int ECS_GSZ_GTIM  = 3;
	localparam int ECS_GSZ_SIZE  = 0;
	localparam int ECS_GBASE_LSB = 2;

	// general-purpose size codes
	localparam logic [2:0] ECS_GSZ_64K = 3'h0;
	localparam logic [2:0] ECS_GSZ_32K = 3'h1;
	localparam logic [2:0] ECS_GSZ_16K = 3'h2;
	localparam logic [2:0] ECS_GSZ_8K  = 3'h3;
	localparam logic [2:0] ECS_GSZ_4K  = 3'h4;
	localparam logic [2:0] ECS_GSZ_2K  = 3'h5;
	localparam logic [2:0] ECS_GSZ_1K  = 3'h6;
	localparam logic [2:0] ECS_GSZ_OFF = 3'h7;

	// fixed i/o windows inside the 4K register block
	localparam logic [11:0] ECS_IO1_LO = 12'h060;
	localparam logic [11:0] ECS_IO1_HI = 12'h7FF;
	localparam logic [11:0] ECS_IO2_LO = 12'h800;

	// select indices for stretch lookup
	localparam logic [1:0] ECS_SEL_IO1 = 2'h0;
	localparam logic [1:0] ECS_SEL_IO2 = 2'h1;
	localparam logic [1:0] ECS_SEL_GP  = 2'h2;
	localparam logic [1:0] ECS_SEL_PRG = 2'h3;

	// stretch sequencer states
	typedef enum logic [1:0] {
		ECS_ST_IDLE = 2'b01,
		ECS_ST_HOLD = 2'b10
	} ecs_state_t;
endpackage

// file: hw/ecs_decode.sv
// ecs_decode: combinational address decode of the four selects, before polarity and timing.
// assumes: address and register fields come from the same clock domain as the caller.
`timescale 1ns/10ps
module ecs_decode
	import ecs_pkg::*;
(
	input  wire logic [15:0] i_addr,       // cpu address
	input  wire logic [3:0]  i_reg_base,   // upper nibble of register block base
	input  wire logic [5:0]  i_gp_base,    // gp base bits, address 15..10
	input  wire logic [2:0]  i_gp_size,    // gp size code
	input  wire logic [1:0]  i_prg_size,   // program size code
	input  wire logic        i_prg_en,     // program select enable
	input  wire logic        i_gp_pri,     // 1: gp wins over program
	output logic             o_hit_io1,    // inside first i/o window
	output logic             o_hit_io2,    // inside second i/o window
	output logic             o_hit_gp,     // gp wins this address
	output logic             o_hit_prg     // program wins this address
);
	logic [5:0] gp_mask;
	logic       gp_raw;
	logic       prg_raw;

	// compare mask per size: one bit per base bit that still counts
	always_comb begin
		unique case (i_gp_size)
			ECS_GSZ_64K: gp_mask = 6'h00;
			ECS_GSZ_32K: gp_mask = 6'h20;
			ECS_GSZ_16K: gp_mask = 6'h30;
			ECS_GSZ_8K:  gp_mask = 6'h38;
			ECS_GSZ_4K:  gp_mask = 6'h3C;
			ECS_GSZ_2K:  gp_mask = 6'h3E;
			ECS_GSZ_1K:  gp_mask = 6'h3F;
			ECS_GSZ_OFF: gp_mask = 6'h00;
		endcase
	end

	// gp window start compares against address 15..10; size 0K is its only disable
	assign gp_raw  = (i_gp_size != ECS_GSZ_OFF) &&
	                 (((i_addr[15:10] ^ i_gp_base) & gp_mask) == 6'h00);

	// program window ends at the top of memory, start fixed by size
	always_comb begin
		unique case (i_prg_size)
			2'h0:    prg_raw = i_prg_en;
			2'h1:    prg_raw = i_prg_en & i_addr[15];
			2'h2:    prg_raw = i_prg_en & (&i_addr[15:14]);
			default: prg_raw = i_prg_en & (&i_addr[15:13]);
		endcase
	end

	// fixed i/o windows within the register block's 4K page
	assign o_hit_io1 = (i_addr[15:12] == i_reg_base) &&
	                   (i_addr[11:0] >= ECS_IO1_LO) && (i_addr[11:0] <= ECS_IO1_HI);
	assign o_hit_io2 = (i_addr[15:12] == i_reg_base) && (i_addr[11:0] >= ECS_IO2_LO);

	// overlap goes to one select only, chosen by the priority bit
	assign o_hit_gp  = gp_raw & (i_gp_pri | ~prg_raw);
	assign o_hit_prg = prg_raw & (~i_gp_pri | ~gp_raw);
endmodule // ecs_decode

// file: hw/ecs_top.sv
// ecs_top: expansion chip-select unit with APB register access.
// assumes: cpu bus signals (address, address-valid, e-high, e-cycle end) are synchronous to i_ref_clk;
// mode strap is a level sampled at reset release; stretch cycles are counted on the e-cycle-end pulse.
`timescale 1ns/10ps
module ecs_top
	import ecs_pkg::*;
(
	input  wire logic                i_ref_clk,    // 125 MHz clock
	input  wire logic                i_nrst,       // synchronous reset, active low
	input  wire logic                i_expanded,   // mode strap: 1 expanded, 0 single-chip
	input  wire logic [15:0]         i_addr,       // cpu address
	input  wire logic                i_addr_valid, // cpu address-valid window
	input  wire logic                i_e_high,     // E clock high phase
	input  wire logic                i_e_end,      // pulse at the end of each E cycle
	input  wire logic                psel,         // apb select
	input  wire logic                penable,      // apb access phase
	input  wire logic                pwrite,       // apb direction
	input  wire logic [ECS_AW-1:0]   paddr,        // apb byte address
	input  wire logic [31:0]         pwdata,       // apb write data
	input  wire logic [3:0]          pstrb,        // apb byte strobes
	output logic      [31:0]         prdata,       // apb read data
	output logic                     pready,       // apb ready
	output logic                     pslverr,      // apb error on unmapped address
	output logic                     o_sel_io1,    // first i/o select pin level
	output logic                     o_sel_io2,    // second i/o select pin level
	output logic                     o_sel_gp,     // general-purpose select pin level
	output logic                     o_sel_prg_n,  // program select, active low
	output logic                     o_stretch     // high while the E cycle is held
);
	typedef struct packed {
		logic [7:0]  stretch;   // select_stretch_reg
		logic [7:0]  control;   // select_control_reg
		logic [7:0]  gp_base;   // gp_base_reg
		logic [7:0]  gp_size;   // gp_size_timing_reg
		logic [3:0]  reg_base;  // register block nibble
		logic        strap_done;
		ecs_state_t  state;
		logic [1:0]  count;
		logic [31:0] rdata;
		logic        sel_io1;
		logic        sel_io2;
		logic        sel_gp;
		logic        sel_prg_n;
	} ecs_regs_t;

	ecs_regs_t  cur;
	ecs_regs_t  next_cur;
	logic       hit_io1;
	logic       hit_io2;
	logic       hit_gp;
	logic       hit_prg;
	logic       act_io1;
	logic       act_io2;
	logic       act_gp;
	logic       act_prg;
	logic       wr_en;
	logic       mapped;
	logic [1:0] need;

	// decode of one stretch field
	function automatic logic [1:0] stretch_of(input logic [7:0] r, input logic [1:0] sel);
		unique case (sel)
			ECS_SEL_IO1: stretch_of = r[ECS_STR_IO1 +: 2];
			ECS_SEL_IO2: stretch_of = r[ECS_STR_IO2 +: 2];
			ECS_SEL_GP:  stretch_of = r[ECS_STR_GP +: 2];
			default:     stretch_of = r[ECS_STR_PRG +: 2];
		endcase
	endfunction

	// timing gate then polarity: timing 1 means whole address-valid, 0 means E high only
	function automatic logic drive(input logic hit, input logic pol, input logic av,
	                               input logic aval, input logic ehi);
		drive = (hit & aval & (av | ehi)) ~^ pol;
	endfunction

	// window decode
	ecs_decode u_decode (
		.i_addr     (i_addr),
		.i_reg_base (cur.reg_base),
		.i_gp_base  (cur.gp_base[7:ECS_GBASE_LSB]),
		.i_gp_size  (cur.gp_size[ECS_GSZ_SIZE +: 3]),
		.i_prg_size (cur.control[ECS_CTL_PSIZ +: 2]),
		.i_prg_en   (cur.control[ECS_CTL_PEN]),
		.i_gp_pri   (cur.control[ECS_CTL_GPRI]),
		.o_hit_io1  (hit_io1),
		.o_hit_io2  (hit_io2),
		.o_hit_gp   (hit_gp),
		.o_hit_prg  (hit_prg)
	);

	// enables gate the i/o windows; gp enable is its size code
	assign act_io1 = hit_io1 & cur.control[ECS_CTL_IO_SEL1_ENABLE];
	assign act_io2 = hit_io2 & cur.control[ECS_CTL_IO_SEL2_ENABLE];
	assign act_gp  = hit_gp;
	assign act_prg = hit_prg;

	// longest stretch among the selects active this cycle
	always_comb begin
		need = 2'h0;
		if (act_io1 && stretch_of(cur.stretch, ECS_SEL_IO1) > need)
			need = stretch_of(cur.stretch, ECS_SEL_IO1);
		if (act_io2 && stretch_of(cur.stretch, ECS_SEL_IO2) > need)
			need = stretch_of(cur.stretch, ECS_SEL_IO2);
		if (act_gp && stretch_of(cur.stretch, ECS_SEL_GP) > need)
			need = stretch_of(cur.stretch, ECS_SEL_GP);
		if (act_prg && stretch_of(cur.stretch, ECS_SEL_PRG) > need)
			need = stretch_of(cur.stretch, ECS_SEL_PRG);
	end

	assign wr_en  = psel & penable & pwrite & pstrb[0];
	assign mapped = (paddr == ECS_ADR_STRETCH) || (paddr == ECS_ADR_CONTROL) ||
	                (paddr == ECS_ADR_GP_BASE) || (paddr == ECS_ADR_GP_SIZE) ||
	                (paddr == ECS_ADR_REGBASE) || (paddr == ECS_ADR_STATUS);

	// next state of all registers
	always_comb begin
		next_cur = cur;

		// apb writes: zero wait, take effect at the access edge
		if (wr_en) begin
			unique case (paddr)
				ECS_ADR_STRETCH: next_cur.stretch  = pwdata[7:0];
				ECS_ADR_CONTROL: next_cur.control  = pwdata[7:0];
				ECS_ADR_GP_BASE: next_cur.gp_base  = pwdata[7:0] & ECS_GP_BASE_WM;
				ECS_ADR_GP_SIZE: next_cur.gp_size  = pwdata[7:0] & ECS_GP_SIZE_WM;
				ECS_ADR_REGBASE: next_cur.reg_base = pwdata[3:0];
				default: ;
			endcase
		end

		// read data registered in setup so it is stable in the access phase
		if (psel && !penable) begin
			next_cur.rdata = 32'h0000_0000;
			unique case (paddr)
				ECS_ADR_STRETCH: next_cur.rdata[7:0] = cur.stretch;
				ECS_ADR_CONTROL: next_cur.rdata[7:0] = cur.control;
				ECS_ADR_GP_BASE: next_cur.rdata[7:0] = cur.gp_base;
				ECS_ADR_GP_SIZE: next_cur.rdata[7:0] = cur.gp_size;
				ECS_ADR_REGBASE: next_cur.rdata[3:0] = cur.reg_base;
				ECS_ADR_STATUS:  next_cur.rdata[7:0] = {cur.state == ECS_ST_HOLD, 1'b0, cur.count,
				                                        o_sel_io1, o_sel_io2, o_sel_gp, o_sel_prg_n};
				default: ;
			endcase
		end

		// mode-dependent defaults caught once after reset release, never inside the reset
		if (!cur.strap_done) begin
			next_cur.strap_done = 1'b1;
			next_cur.control[ECS_CTL_PEN] = i_expanded;
			next_cur.stretch[ECS_STR_PRG +: 2] = i_expanded ? ECS_STR_ONE : 2'h0;
		end

		// stretch sequencer: hold the E cycle for the chosen number of E ends
		unique case (cur.state)
			ECS_ST_IDLE: begin
				if (i_e_end && i_addr_valid && need != 2'h0) begin
					next_cur.state = ECS_ST_HOLD;
					next_cur.count = need;
				end
			end
			ECS_ST_HOLD: begin
				if (i_e_end) begin
					next_cur.count = cur.count - 2'h1;
					if (cur.count == 2'h1)
						next_cur.state = ECS_ST_IDLE;
				end
			end
		endcase

		// registered select pins, one cycle after the bus signals
		next_cur.sel_io1 = drive(act_io1, cur.control[ECS_CTL_IO_SEL1_POLARITY],
		                         cur.gp_size[ECS_GSZ_IO_SEL1_TIMING], i_addr_valid, i_e_high);
		next_cur.sel_io2 = drive(act_io2, cur.control[ECS_CTL_IO_SEL2_POLARITY],
		                         cur.gp_size[ECS_GSZ_IO_SEL2_TIMING], i_addr_valid, i_e_high);
		next_cur.sel_gp  = drive(act_gp, cur.gp_size[ECS_GSZ_GPOL],
		                         cur.gp_size[ECS_GSZ_GTIM], i_addr_valid, i_e_high);
		next_cur.sel_prg_n = ~(act_prg & i_addr_valid);

		// synchronous reset: constants only; strap capture follows on the next edge
		if (!i_nrst) begin
			next_cur.stretch    = ECS_RST_STRETCH;
			next_cur.control    = ECS_RST_CONTROL;
			next_cur.gp_base    = ECS_RST_GP_BASE;
			next_cur.gp_size    = ECS_RST_GP_SIZE;
			next_cur.reg_base   = ECS_RST_REGBASE;
			next_cur.strap_done = 1'b0;
			next_cur.state      = ECS_ST_IDLE;
			next_cur.count      = 2'h0;
			next_cur.rdata      = 32'h0000_0000;
			next_cur.sel_io1    = 1'b1;
			next_cur.sel_io2    = 1'b1;
			next_cur.sel_gp     = 1'b1;
			next_cur.sel_prg_n  = 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		cur <= next_cur;
	end

	// apb answers at once; unmapped addresses error and read zero
	assign pready      = 1'b1;
	assign pslverr     = psel & penable & ~mapped;
	assign prdata      = cur.rdata;
	assign o_sel_io1   = cur.sel_io1;
	assign o_sel_io2   = cur.sel_io2;
	assign o_sel_gp    = cur.sel_gp;
	assign o_sel_prg_n = cur.sel_prg_n;
	assign o_stretch   = (cur.state == ECS_ST_HOLD);
endmodule // ecs_top

// file: sim/ecs_ext_dev.sv
// ecs_ext_dev: devices on the expansion bus, each woken by its own select pin.
// assumes: board straps give the active level of the io and general devices.
`timescale 1ns/10ps
module ecs_ext_dev (
	input  wire logic       i_sel_io1,   // first i/o pin
	input  wire logic       i_sel_io2,   // second i/o pin
	input  wire logic       i_sel_gp,    // general pin
	input  wire logic       i_sel_prg_n, // program memory pin
	input  wire logic [2:0] i_act_lvl,   // strapped levels io1, io2, gp
	output logic      [3:0] o_seen       // devices that see a select
);
	// program memory is wired active low, the rest follow their straps
	assign o_seen = {i_sel_io1 == i_act_lvl[2], i_sel_io2 == i_act_lvl[1],
		i_sel_gp == i_act_lvl[0], !i_sel_prg_n};
endmodule // ecs_ext_dev

// file: sim/ecs_top_props.sv
// ecs_top_props: assertions on the chip-select pins and the stretch hold output.
// assumes: bound to ecs_top; shadows control and size registers from apb writes.
`timescale 1ns/10ps
module ecs_top_props
	import ecs_pkg::*;
(
	input wire logic        i_ref_clk,    // clock
	input wire logic        i_nrst,       // reset
	input wire logic [15:0] i_addr,       // address
	input wire logic        i_addr_valid, // address valid
	input wire logic        i_e_high,     // e high
	input wire logic        i_e_end,      // e end
	input wire logic        psel,         // apb
	input wire logic        penable,      // apb
	input wire logic        pwrite,       // apb
	input wire logic [17:0] paddr,        // apb
	input wire logic [31:0] pwdata,       // apb
	input wire logic [3:0]  pstrb,        // apb
	input wire logic        o_sel_io1,    // pin
	input wire logic        o_sel_io2,    // pin
	input wire logic        o_sel_gp,     // pin
	input wire logic        o_sel_prg_n,  // pin
	input wire logic        o_stretch     // hold
);
	typedef struct packed {logic [7:0] ctl; logic [7:0] gsz; logic [2:0] cnt;} ecs_chk_t;
	ecs_chk_t st;
	ecs_chk_t next_st;
	logic     wr;
	// shadow config; cnt counts e-cycle ends seen while the hold is up
	assign wr = psel && penable && pwrite && pstrb[0];
	always_comb begin
		next_st = st;
		if (wr && paddr == ECS_ADR_CONTROL) next_st.ctl = pwdata[7:0];
		if (wr && paddr == ECS_ADR_GP_SIZE) next_st.gsz = pwdata[7:0];
		next_st.cnt = o_stretch ? st.cnt + 3'(i_e_end) : 3'h0;
		if (!i_nrst) next_st = {8'h00, ECS_RST_GP_SIZE, 3'h0};
	end
	always_ff @(posedge i_ref_clk) st <= next_st;
	// pins lag a register write by one edge, so the checks read the config one edge late
	logic [7:0] ctl_d;
	logic [7:0] gsz_d;
	always_ff @(posedge i_ref_clk) begin
		ctl_d <= st.ctl;
		gsz_d <= st.gsz;
	end
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);
	io1_off_idle_a: assert property (!ctl_d[7] |-> o_sel_io1 == !ctl_d[6])
		else $error("io1 active while disabled");
	io2_off_idle_a: assert property (!ctl_d[5] |-> o_sel_io2 == !ctl_d[4])
		else $error("io2 active while disabled");
	io1_e_time_a: assert property (!gsz_d[7] && !$past(i_e_high) |-> o_sel_io1 == !ctl_d[6])
		else $error("io1 active outside e high");
	io2_e_time_a: assert property (!gsz_d[6] && !$past(i_e_high) |-> o_sel_io2 == !ctl_d[4])
		else $error("io2 active outside e high");
	gp_size_off_a: assert property (gsz_d[2:0] == 3'h7 |-> o_sel_gp == !gsz_d[4])
		else $error("general select active at size zero");
	gp_e_time_a: assert property (!gsz_d[3] && !$past(i_e_high) |-> o_sel_gp == !gsz_d[4])
		else $error("general select outside e high");
	prg_av_only_a: assert property (!$past(i_addr_valid) |-> o_sel_prg_n)
		else $error("program select without address valid");
	io1_low_gap_a: assert property (($past(i_addr) & 16'h0FFF) < 16'h0060 |-> o_sel_io1 == !ctl_d[6])
		else $error("io1 active below its window");
	gp_prg_excl_a: assert property (!(o_sel_gp == gsz_d[4] && !o_sel_prg_n))
		else $error("general and program selects both active");
	stretch_start_a: assert property ($rose(o_stretch) |-> $past(i_e_end) && $past(i_addr_valid))
		else $error("hold began without a valid cycle end");
	stretch_bound_a: assert property (o_stretch |-> st.cnt <= 3'h2)
		else $error("hold longer than three e cycles");
endmodule // ecs_top_props

bind ecs_top ecs_top_props u_props (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_addr(i_addr),
	.i_addr_valid(i_addr_valid), .i_e_high(i_e_high), .i_e_end(i_e_end), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.o_sel_io1(o_sel_io1), .o_sel_io2(o_sel_io2), .o_sel_gp(o_sel_gp),
	.o_sel_prg_n(o_sel_prg_n), .o_stretch(o_stretch));

// file: sim/tb_expansion_chip_select_unit.sv
// tb_expansion_chip_select_unit: random decode checks, reset values and hold lengths.
// assumes: ecs_top and ecs_ext_dev compiled; checker bound by its own file.
`timescale 1ns/10ps
module tb_expansion_chip_select_unit
	import ecs_pkg::*;
;
	logic i_ref_clk, i_nrst, i_expanded, i_addr_valid, i_e_high, i_e_end, psel, penable, pwrite;
	logic pready, pslverr, o_sel_io1, o_sel_io2, o_sel_gp, o_sel_prg_n, o_stretch, se, av, eh;
	logic [15:0] i_addr, a;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, rd, lfsr;
	logic [3:0]  pstrb, m_rb, seen;
	logic [7:0]  m_ctl, m_gsz, m_base;
	int          err_total, n_compared, cyc, cnt;
	ecs_top u_dut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_expanded(i_expanded), .i_addr(i_addr),
		.i_addr_valid(i_addr_valid), .i_e_high(i_e_high), .i_e_end(i_e_end), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .o_sel_io1(o_sel_io1),
		.o_sel_io2(o_sel_io2), .o_sel_gp(o_sel_gp), .o_sel_prg_n(o_sel_prg_n), .o_stretch(o_stretch));
	ecs_ext_dev u_dev (.i_sel_io1(o_sel_io1), .i_sel_io2(o_sel_io2), .i_sel_gp(o_sel_gp),
		.i_sel_prg_n(o_sel_prg_n), .i_act_lvl({m_ctl[6], m_ctl[4], m_gsz[4]}), .o_seen(seen));
	// clock and hang guard
	initial begin
		i_ref_clk = 1'b0;
		forever #4 i_ref_clk = ~i_ref_clk;
	end
	always @(posedge i_ref_clk) begin
		cyc++;
		if (cyc == 6000) begin
			err_total++;
			finish_test();
		end
	end
	task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	function logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// one apb transfer; request held until pready is sampled high
	task apb(input logic [15:0] idx, input logic w, input logic [7:0] d, input logic [3:0] s);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		pstrb <= s;
		@(posedge i_ref_clk) penable <= 1'b1;
		do @(posedge i_ref_clk); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// let an edge pass so a following call never re-drives psel in this time step
		@(posedge i_ref_clk);
	endtask
	task rst(input logic ex);
		i_expanded <= ex;
		i_nrst <= 1'b0;
		repeat (6) @(posedge i_ref_clk);
		i_nrst <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
	endtask
	// which devices should see a select, from the mirrored registers
	function logic [3:0] exp_sel(input logic [15:0] ad, input logic v, input logic e);
		logic [5:0] gm;
		logic [2:0] pm;
		logic gh, ph, io1, io2;
		gm = 6'(6'h3F << (6 - m_gsz[2:0]));
		pm = 3'(3'h7 << (3 - m_ctl[1:0]));
		gh = m_gsz[2:0] != 3'h7 && ((ad[15:10] ^ m_base[7:2]) & gm) == 6'h0;
		ph = m_ctl[2] && (ad[15:13] & pm) == pm;
		if (gh && ph) begin
			if (m_ctl[3]) ph = 1'b0;
			else gh = 1'b0;
		end
		io1 = m_ctl[7] && ad[15:12] == m_rb && ad[11:0] >= 12'h060 && !ad[11] && (m_gsz[7] || e);
		io2 = m_ctl[5] && ad[15:12] == m_rb && ad[11] && (m_gsz[6] || e);
		return {io1 && v, io2 && v, gh && v && (m_gsz[3] || e), ph && v};
	endfunction
	task finish_test();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		{i_nrst, i_expanded, i_addr_valid, i_e_high, i_e_end, psel, penable, pwrite} = 8'h00;
		{i_addr, paddr, pwdata, pstrb} = 70'h0;
		{m_ctl, m_gsz, m_base, m_rb} = 28'h0;
		lfsr = 32'hF9A2;
		// reset values in both modes, a dropped strobe and an unmapped read
		for (int x = 0; x < 2; x++) begin
			rst(x[0]);
			apb(ECS_IDX_CONTROL, 1'b1, 8'hFF, 4'h0);
			apb(ECS_IDX_CONTROL, 1'b0, 8'h00, 4'h1);
			chk("control", rd, {29'h0, x[0], 2'h0});
			apb(ECS_IDX_STRETCH, 1'b0, 8'h00, 4'h1);
			chk("stretch", rd, {31'h0, x[0]});
			apb(ECS_IDX_GP_SIZE, 1'b0, 8'h00, 4'h1);
			chk("gp size", rd, 32'h07);
		end
		apb(16'h0000, 1'b0, 8'h00, 4'h1);
		chk("unmapped", {se, rd[30:0]}, 32'h80000000);
		$display("test reset done");
		// random configurations, every size code walked
		for (int c = 0; c < 32; c++) begin
			lfsr = nxt(lfsr);
			m_ctl = {lfsr[7:3], lfsr[8] | lfsr[9], c[4:3]};
			m_gsz = {lfsr[15:11], c[2:0]};
			m_base = lfsr[23:16];
			m_rb = lfsr[27:24];
			apb(ECS_IDX_CONTROL, 1'b1, m_ctl, 4'h1);
			apb(ECS_IDX_GP_SIZE, 1'b1, m_gsz, 4'h1);
			apb(ECS_IDX_GP_BASE, 1'b1, m_base, 4'h1);
			apb(ECS_IDX_REGBASE, 1'b1, {4'h0, m_rb}, 4'h1);
			repeat (12) begin
				lfsr = nxt(lfsr);
				a = lfsr[15:0];
				if (lfsr[17:16] == 2'h0) a[15:10] = m_base[7:2];
				if (lfsr[17:16] == 2'h1) a[15:12] = m_rb;
				av = lfsr[18] | lfsr[19];
				eh = lfsr[20];
				i_addr <= a;
				i_addr_valid <= av;
				i_e_high <= eh;
				@(posedge i_ref_clk);
				#1 chk("selects", {28'h0, seen}, {28'h0, exp_sel(a, av, eh)});
				@(posedge i_ref_clk);
			end
		end
		$display("test decode done");
		// hold length per program stretch code; other selects off with random codes
		apb(ECS_IDX_CONTROL, 1'b1, 8'h04, 4'h1);
		apb(ECS_IDX_GP_SIZE, 1'b1, 8'h07, 4'h1);
		for (int n = 0; n < 4; n++) begin
			lfsr = nxt(lfsr);
			apb(ECS_IDX_STRETCH, 1'b1, {lfsr[5:0], n[1:0]}, 4'h1);
			{i_addr, i_addr_valid, i_e_high, i_e_end} <= {16'h4000, 3'b111};
			@(posedge i_ref_clk) i_e_end <= 1'b0;
			i_addr_valid <= 1'b0;
			cnt = 0;
			#1;
			while (o_stretch === 1'b1 && cnt < 6) begin
				@(posedge i_ref_clk) i_e_end <= 1'b1;
				@(posedge i_ref_clk) i_e_end <= 1'b0;
				cnt++;
				#1;
			end
			chk("hold cycles", 32'(cnt), 32'(n));
			@(posedge i_ref_clk);
		end
		$display("test stretch done");
		finish_test();
	end
endmodule // tb_expansion_chip_select_unit
